/* File: hw/lpac_pkg.sv */
// Package of constants and types for the LED pattern and audio control registers
package lpac_pkg;

	// ****************************************
	// Clock and audio sampling rates
	// ****************************************
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned RATE_PLAIN_HZ = 122;
	localparam int unsigned RATE_AVG_HZ = 244;
	localparam int unsigned AVG_SAMPLES = 64;
	// Divider counts, rounded down so the rate never falls below the figure
	localparam int unsigned DIV_PLAIN = CLK_HZ / RATE_PLAIN_HZ;
	localparam int unsigned DIV_AVG = CLK_HZ / RATE_AVG_HZ;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] ADDR_PAT_CTRL = 8'h11;
	localparam logic [7:0] ADDR_SYNC_CTRL2 = 8'h2b;
	localparam logic [7:0] ADDR_LEVEL = 8'h2c;
	localparam logic [7:0] ADDR_CMD_BASE = 8'h30;
	localparam int unsigned NUM_CMDS = 8;
	localparam logic [7:0] CMD_SPAN = 8'h10;

	// ****************************************
	// Field layouts and reset values
	// ****************************************
	localparam int unsigned CTRL2_W = 5;
	localparam int unsigned CTRL2_AVG_BIT = 4;
	localparam int unsigned CTRL2_MODE_LSB = 2;
	localparam int unsigned CTRL2_SPEED_LSB = 0;
	localparam logic [4:0] CTRL2_RESET = 5'h00;
	localparam int unsigned PAT_W = 4;
	localparam int unsigned PAT_LOG_BIT = 0;
	localparam logic [3:0] PAT_RESET = 4'h0;
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam int unsigned A_RED_LSB = 5;
	localparam int unsigned A_GREEN_LSB = 2;
	localparam int unsigned A_EXEC_HI_LSB = 0;
	localparam int unsigned B_EXEC_LO_LSB = 6;
	localparam int unsigned B_BLUE_LSB = 3;
	localparam int unsigned B_TRANS_LSB = 0;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// ****************************************
	// Intensity codes and percentages
	// ****************************************
	localparam logic [2:0] CODE_OFF = 3'h0;
	localparam logic [2:0] CODE_FULL = 3'h7;
	localparam logic [6:0] PCT_OFF = 7'h00;
	localparam logic [6:0] PCT_FULL = 7'h64;

	// Response speed of the LED follower
	typedef enum logic [1:0] {
		SPEED_FASTEST,
		SPEED_FAST,
		SPEED_MEDIUM,
		SPEED_SLOW
	} lpac_speed_type;

endpackage

/* File: hw/lpac_level_sampler.sv */
// Audio level sampler with optional 64-sample averaging
`timescale 1ns/10ps
module lpac_level_sampler #(
	parameter int unsigned DIV_PLAIN = lpac_pkg::DIV_PLAIN,
	parameter int unsigned DIV_AVG = lpac_pkg::DIV_AVG,
	parameter int unsigned LEVEL_W = 8
) (
	// Clock, reset, enable
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// Control and sample
	input wire logic avg_en_i,
	input wire logic [LEVEL_W-1:0] sample_i,
	// Result
	output logic [LEVEL_W-1:0] level_o,
	output logic update_o
);

	localparam int unsigned CNT_W = $clog2(DIV_PLAIN + 1);
	localparam int unsigned AVG_W = $clog2(lpac_pkg::AVG_SAMPLES);
	localparam int unsigned ACC_W = LEVEL_W + AVG_W;
	localparam logic [AVG_W-1:0] AVG_LAST = AVG_W'(lpac_pkg::AVG_SAMPLES - 1);

	logic [CNT_W-1:0] div_reg, div_next;
	logic [AVG_W-1:0] cnt_reg, cnt_next;
	logic [ACC_W-1:0] acc_reg, acc_next;
	logic [LEVEL_W-1:0] level_reg, level_next;
	logic update_reg, update_next;
	logic avg_q_reg, avg_q_next;
	logic tick;
	logic [ACC_W-1:0] acc_sum;

	// Sample divider, accumulator and level update
	always_comb begin
		div_next = div_reg + 1'b1;
		cnt_next = cnt_reg;
		acc_next = acc_reg;
		level_next = level_reg;
		update_next = 1'b0;
		avg_q_next = avg_en_i;
		acc_sum = acc_reg + ACC_W'(sample_i);
		tick = avg_q_reg ? (div_reg == CNT_W'(DIV_AVG - 1)) : (div_reg == CNT_W'(DIV_PLAIN - 1));
		if (avg_en_i != avg_q_reg) begin
			// Mode change restarts the window so no mixed average is reported
			div_next = '0;
			cnt_next = '0;
			acc_next = '0;
		end else if (tick) begin
			div_next = '0;
			if (!avg_q_reg) begin
				level_next = sample_i;
				update_next = 1'b1;
			end else if (cnt_reg == AVG_LAST) begin
				level_next = acc_sum[ACC_W-1:AVG_W];
				acc_next = '0;
				cnt_next = '0;
				update_next = 1'b1;
			end else begin
				acc_next = acc_sum;
				cnt_next = cnt_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			div_reg <= '0;
			cnt_reg <= '0;
			acc_reg <= '0;
			level_reg <= '0;
			update_reg <= 1'b0;
			avg_q_reg <= 1'b0;
		end else if (ce_i) begin
			div_reg <= div_next;
			cnt_reg <= cnt_next;
			acc_reg <= acc_next;
			level_reg <= level_next;
			update_reg <= update_next;
			avg_q_reg <= avg_q_next;
		end
	end

	assign level_o = level_reg;
	assign update_o = update_reg;

	// ****************************************
	// Checks
	// ****************************************
	plain_update_a: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && tick && !avg_q_reg && (avg_en_i == avg_q_reg)
		|=> update_o && level_o == $past(sample_i))
		else $error("plain sample not passed to level");

	avg_hold_a: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && avg_q_reg && !(tick && cnt_reg == AVG_LAST) |=> !update_o)
		else $error("averaged level updated early");

endmodule

/* File: hw/lpac_ctrl_regs.sv */
// Audio-sync control register, pattern command bank and intensity mapping
`timescale 1ns/10ps

// Behaviour
// - Sync control 2: bits 7-5 read zero, avg/mode/speed fields, reset zero.
// - Without averaging, sample at 122 Hz and refresh level every 8.2 ms.
// - With averaging, sample at 244 Hz, average 64, refresh every 262 ms.
// - Speed code sets LED follow rate: 00 fastest default, 11 slow.
// - Command word A: red 7-5, green 4-2, exec time high 1-0, resets zero.
// - Command word B: exec time low 7-6, blue 5-3, transition 2-0, resets zero.
// - Linear table: 0, 7, 14, 21, 32, 46, 71, 100 percent.
// - Log table: 0, 1, 2, 4, 10, 21, 46, 100 percent.
// - Code 000 is off and 111 is full scale in either mode.
// - Pattern control bit 0 picks linear (0) or log (1) for all colours.
module lpac_ctrl_regs #(
	parameter int unsigned DIV_PLAIN = lpac_pkg::DIV_PLAIN,
	parameter int unsigned DIV_AVG = lpac_pkg::DIV_AVG,
	parameter int unsigned LEVEL_W = 8
) (
	// Clock, reset, enable
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// Register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// Audio side
	input wire logic [LEVEL_W-1:0] audio_sample_i,
	output logic [1:0] filter_mode_o,
	output logic [LEVEL_W-1:0] led_level_o,
	// Pattern side
	input wire logic [2:0] cmd_sel_i,
	output logic [3:0] pattern_ctrl_o,
	output logic [6:0] red_pct_o,
	output logic [6:0] green_pct_o,
	output logic [6:0] blue_pct_o,
	output logic [3:0] exec_time_o,
	output logic [2:0] transition_time_o
);

	// ****************************************
	// Helper functions
	// ****************************************

	// Percent of full scale for a colour code
	function automatic logic [6:0] pct_map(input logic [2:0] code, input logic log_mode);
		logic [6:0] pct;
		pct = lpac_pkg::PCT_OFF;
		case (code)
			3'h1: pct = log_mode ? 7'h01 : 7'h07;
			3'h2: pct = log_mode ? 7'h02 : 7'h0e;
			3'h3: pct = log_mode ? 7'h04 : 7'h15;
			3'h4: pct = log_mode ? 7'h0a : 7'h20;
			3'h5: pct = log_mode ? 7'h15 : 7'h2e;
			3'h6: pct = log_mode ? 7'h2e : 7'h47;
			lpac_pkg::CODE_FULL: pct = lpac_pkg::PCT_FULL;
			default: pct = lpac_pkg::PCT_OFF;
		endcase
		return pct;
	endfunction

	// True when the address falls in the command bank
	function automatic logic cmd_match(input logic [7:0] addr);
		return (addr >= lpac_pkg::ADDR_CMD_BASE) &&
			((addr - lpac_pkg::ADDR_CMD_BASE) < lpac_pkg::CMD_SPAN);
	endfunction

	// Offset into the command bank: bit 0 selects word B, the rest the command
	function automatic logic [3:0] cmd_offset(input logic [7:0] addr);
		logic [7:0] diff;
		diff = addr - lpac_pkg::ADDR_CMD_BASE;
		return diff[3:0];
	endfunction

	// Follower shift for each speed code
	function automatic logic [1:0] speed_shift(input lpac_pkg::lpac_speed_type speed);
		logic [1:0] sh;
		sh = 2'h0;
		case (speed)
			lpac_pkg::SPEED_FASTEST: sh = 2'h0;
			lpac_pkg::SPEED_FAST: sh = 2'h1;
			lpac_pkg::SPEED_MEDIUM: sh = 2'h2;
			lpac_pkg::SPEED_SLOW: sh = 2'h3;
			default: sh = 2'h0;
		endcase
		return sh;
	endfunction

	// ****************************************
	// Register file
	// ****************************************
	localparam int unsigned N = lpac_pkg::NUM_CMDS;

	logic [lpac_pkg::CTRL2_W-1:0] ctrl2_reg, ctrl2_next;
	logic [lpac_pkg::PAT_W-1:0] pat_reg, pat_next;
	logic [7:0] cmd_a_reg [N];
	logic [7:0] cmd_a_next [N];
	logic [7:0] cmd_b_reg [N];
	logic [7:0] cmd_b_next [N];
	logic [7:0] rdata_reg, rdata_next;
	logic [LEVEL_W-1:0] level;
	logic level_update;
	logic [3:0] off;

	// Writes and read mux; reads sample the old value on a same-cycle write
	always_comb begin
		ctrl2_next = ctrl2_reg;
		pat_next = pat_reg;
		cmd_a_next = cmd_a_reg;
		cmd_b_next = cmd_b_reg;
		rdata_next = rdata_reg;
		off = cmd_offset(reg_addr_i);
		if (reg_wr_i) begin
			if (reg_addr_i == lpac_pkg::ADDR_SYNC_CTRL2) begin
				ctrl2_next = reg_wdata_i[lpac_pkg::CTRL2_W-1:0];
			end else if (reg_addr_i == lpac_pkg::ADDR_PAT_CTRL) begin
				pat_next = reg_wdata_i[lpac_pkg::PAT_W-1:0];
			end else if (cmd_match(reg_addr_i)) begin
				if (off[0])
					cmd_b_next[off[3:1]] = reg_wdata_i;
				else
					cmd_a_next[off[3:1]] = reg_wdata_i;
			end
		end
		if (reg_rd_i) begin
			if (reg_addr_i == lpac_pkg::ADDR_SYNC_CTRL2) begin
				rdata_next = {3'h0, ctrl2_reg};
			end else if (reg_addr_i == lpac_pkg::ADDR_PAT_CTRL) begin
				rdata_next = {4'h0, pat_reg};
			end else if (reg_addr_i == lpac_pkg::ADDR_LEVEL) begin
				rdata_next = 8'(level);
			end else if (cmd_match(reg_addr_i)) begin
				rdata_next = off[0] ? cmd_b_reg[off[3:1]] : cmd_a_reg[off[3:1]];
			end else begin
				rdata_next = lpac_pkg::READ_ZERO; // Unmapped reads give zero
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			ctrl2_reg <= lpac_pkg::CTRL2_RESET;
			pat_reg <= lpac_pkg::PAT_RESET;
			rdata_reg <= lpac_pkg::READ_ZERO;
			for (int i = 0; i < N; i++) begin
				cmd_a_reg[i] <= lpac_pkg::CMD_RESET;
				cmd_b_reg[i] <= lpac_pkg::CMD_RESET;
			end
		end else if (ce_i) begin
			ctrl2_reg <= ctrl2_next;
			pat_reg <= pat_next;
			rdata_reg <= rdata_next;
			cmd_a_reg <= cmd_a_next;
			cmd_b_reg <= cmd_b_next;
		end
	end

	// ****************************************
	// Audio level and LED follower
	// ****************************************
	lpac_level_sampler #(
		.DIV_PLAIN(DIV_PLAIN),
		.DIV_AVG(DIV_AVG),
		.LEVEL_W(LEVEL_W)
	) u_sampler (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.avg_en_i(ctrl2_reg[lpac_pkg::CTRL2_AVG_BIT]),
		.sample_i(audio_sample_i),
		.level_o(level),
		.update_o(level_update)
	);

	logic [LEVEL_W-1:0] follow_reg, follow_next;
	logic signed [LEVEL_W:0] diff;
	logic signed [LEVEL_W:0] step;
	logic [1:0] sh;

	// Move a fraction of the gap on each level refresh; slow codes lag more
	always_comb begin
		sh = speed_shift(lpac_pkg::lpac_speed_type'(ctrl2_reg[lpac_pkg::CTRL2_SPEED_LSB +: 2]));
		diff = $signed({1'b0, level}) - $signed({1'b0, follow_reg});
		step = diff >>> sh;
		follow_next = follow_reg;
		if (level_update)
			follow_next = LEVEL_W'($signed({1'b0, follow_reg}) + step);
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i)
			follow_reg <= '0;
		else if (ce_i)
			follow_reg <= follow_next;
	end

	// ****************************************
	// Selected command decode
	// ****************************************
	logic [6:0] red_reg, red_next, green_reg, green_next, blue_reg, blue_next;
	logic [3:0] exec_reg, exec_next;
	logic [2:0] trans_reg, trans_next;
	logic log_sel;
	logic [7:0] word_a, word_b;

	// One log bit steers all three colours
	always_comb begin
		log_sel = pat_reg[lpac_pkg::PAT_LOG_BIT];
		word_a = cmd_a_reg[cmd_sel_i];
		word_b = cmd_b_reg[cmd_sel_i];
		red_next = pct_map(word_a[lpac_pkg::A_RED_LSB +: 3], log_sel);
		green_next = pct_map(word_a[lpac_pkg::A_GREEN_LSB +: 3], log_sel);
		blue_next = pct_map(word_b[lpac_pkg::B_BLUE_LSB +: 3], log_sel);
		exec_next = {word_a[lpac_pkg::A_EXEC_HI_LSB +: 2], word_b[lpac_pkg::B_EXEC_LO_LSB +: 2]};
		trans_next = word_b[lpac_pkg::B_TRANS_LSB +: 3];
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			red_reg <= lpac_pkg::PCT_OFF;
			green_reg <= lpac_pkg::PCT_OFF;
			blue_reg <= lpac_pkg::PCT_OFF;
			exec_reg <= 4'h0;
			trans_reg <= 3'h0;
		end else if (ce_i) begin
			red_reg <= red_next;
			green_reg <= green_next;
			blue_reg <= blue_next;
			exec_reg <= exec_next;
			trans_reg <= trans_next;
		end
	end

	// Outputs come straight from registers
	assign reg_rdata_o = rdata_reg;
	assign filter_mode_o = ctrl2_reg[lpac_pkg::CTRL2_MODE_LSB +: 2];
	assign led_level_o = follow_reg;
	assign pattern_ctrl_o = pat_reg;
	assign red_pct_o = red_reg;
	assign green_pct_o = green_reg;
	assign blue_pct_o = blue_reg;
	assign exec_time_o = exec_reg;
	assign transition_time_o = trans_reg;

	// ****************************************
	// Checks
	// ****************************************
	ctrl2_read_a: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && reg_rd_i && reg_addr_i == 8'h2b |=> reg_rdata_o == {3'h0, $past(ctrl2_reg)})
		else $error("sync control 2 readback wrong");

	ctrl2_reset_a: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		$fell(reset_i) |-> ctrl2_reg == 5'h00 && cmd_a_reg[0] == 8'h00 && cmd_b_reg[7] == 8'h00)
		else $error("registers not zero after reset");

	speed_fastest_a: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && level_update && ctrl2_reg[1:0] == 2'h0 |=> led_level_o == $past(level))
		else $error("fastest speed did not follow level");

	word_a_fields_a: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i |=> exec_time_o[3:2] == $past(cmd_a_reg[cmd_sel_i][1:0]) &&
			red_pct_o == pct_map($past(cmd_a_reg[cmd_sel_i][7:5]), $past(pat_reg[0])))
		else $error("command word A fields misplaced");

	word_b_fields_a: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i |=> exec_time_o[1:0] == $past(cmd_b_reg[cmd_sel_i][7:6]) &&
			transition_time_o == $past(cmd_b_reg[cmd_sel_i][2:0]))
		else $error("command word B fields misplaced");

	linear_map_a: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && !pat_reg[0] && word_a[4:2] == 3'h4 |=> green_pct_o == 7'h20)
		else $error("linear green code 100 not 32 percent");

	log_map_a: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && pat_reg[0] && word_b[5:3] == 3'h6 |=> blue_pct_o == 7'h2e)
		else $error("log blue code 110 not 46 percent");

	code_ends_a: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && word_a[7:5] == 3'h7 ##1 ce_i && word_a[7:5] == 3'h0
		|-> red_pct_o == 7'h64 ##1 red_pct_o == 7'h00)
		else $error("full or off code mapped wrong");

	mode_pass_a: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		ce_i && reg_wr_i && reg_addr_i == 8'h2b |=> filter_mode_o == $past(reg_wdata_i[3:2]))
		else $error("filter mode not stored as written");

endmodule

/* File: dv/tb_lpac_ctrl_regs.sv */
// Self-checking testbench for the LED pattern and audio control registers
`timescale 1ns/10ps
module tb_lpac_ctrl_regs;

	// ****************************************
	// Signals and design under test
	// ****************************************
	typedef struct packed {
		logic log_sel;
		logic [2:0] code;
		logic [6:0] pct;
	} lpac_row_type;

	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic ce_i = 1'b1;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [7:0] reg_rdata_o;
	logic [7:0] audio_sample_i = 8'h00;
	logic [1:0] filter_mode_o;
	logic [7:0] led_level_o;
	logic [2:0] cmd_sel_i = 3'h0;
	logic [3:0] pattern_ctrl_o;
	logic [6:0] red_pct_o;
	logic [6:0] green_pct_o;
	logic [6:0] blue_pct_o;
	logic [3:0] exec_time_o;
	logic [2:0] transition_time_o;
	int num_errors = 0;
	int tests_run = 0;
	logic [7:0] rd_val;
	int n_cyc;
	lpac_row_type rows [16];

	// Short dividers keep the averaging window within a few hundred cycles
	lpac_ctrl_regs #(.DIV_PLAIN(20), .DIV_AVG(10), .LEVEL_W(8)) lpac_ctrl_regs_inst (
		.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.audio_sample_i(audio_sample_i), .filter_mode_o(filter_mode_o),
		.led_level_o(led_level_o), .cmd_sel_i(cmd_sel_i),
		.pattern_ctrl_o(pattern_ctrl_o), .red_pct_o(red_pct_o),
		.green_pct_o(green_pct_o), .blue_pct_o(blue_pct_o),
		.exec_time_o(exec_time_o), .transition_time_o(transition_time_o)
	);

	// 20 MHz clock
	always #25 mclk_i = ~mclk_i;

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Strobes rise 1 ns after an edge and drop 1 ns after the taking edge
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge mclk_i) #1;
		reg_wr_i = 1'b1;
		reg_addr_i = addr;
		reg_wdata_i = data;
		@(posedge mclk_i) #1;
		reg_wr_i = 1'b0;
	endtask

	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		@(posedge mclk_i) #1;
		reg_rd_i = 1'b1;
		reg_addr_i = addr;
		@(posedge mclk_i) #1;
		reg_rd_i = 1'b0;
		data = reg_rdata_o;
	endtask

	// Poll the level register; a bound that runs out ends the run
	task automatic wait_level(input logic [7:0] exp);
		logic [7:0] v;
		int n;
		v = 8'h00;
		for (n = 0; n < 500 && v !== exp; n++) begin
			rd(8'h2c, v);
		end
		check(v, exp, "level wait");
		if (v !== exp) begin
			complete_run();
		end
	endtask

	// Wait for the follower to reach a value; n counts the edges waited
	task automatic wait_led(input logic [7:0] exp, output int n);
		for (n = 0; n < 100 && led_level_o !== exp; n++) begin
			@(posedge mclk_i) #1;
		end
		check(led_level_o, exp, "led wait");
		if (led_level_o !== exp) begin
			complete_run();
		end
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		// Percent tables, linear then logarithmic
		rows = '{
			'{1'b0, 3'h0, 7'h00}, '{1'b0, 3'h1, 7'h07}, '{1'b0, 3'h2, 7'h0e},
			'{1'b0, 3'h3, 7'h15}, '{1'b0, 3'h4, 7'h20}, '{1'b0, 3'h5, 7'h2e},
			'{1'b0, 3'h6, 7'h47}, '{1'b0, 3'h7, 7'h64}, '{1'b1, 3'h0, 7'h00},
			'{1'b1, 3'h1, 7'h01}, '{1'b1, 3'h2, 7'h02}, '{1'b1, 3'h3, 7'h04},
			'{1'b1, 3'h4, 7'h0a}, '{1'b1, 3'h5, 7'h15}, '{1'b1, 3'h6, 7'h2e},
			'{1'b1, 3'h7, 7'h64}};
		repeat (10) @(posedge mclk_i);
		#1;
		reset_i = 1'b0;
		// Reset state of red, blue, exec, mode and follower outputs, of ctrl2 and of two command words
		check({1'b0, red_pct_o}, 8'h00, "red reset");
		check({1'b0, blue_pct_o}, 8'h00, "blue reset");
		check({4'h0, exec_time_o}, 8'h00, "exec reset");
		check({6'h00, filter_mode_o}, 8'h00, "mode reset");
		check(led_level_o, 8'h00, "led reset");
		rd(8'h2b, rd_val);
		check(rd_val, 8'h00, "ctrl2 reset");
		rd(8'h30, rd_val);
		check(rd_val, 8'h00, "word a reset");
		rd(8'h3f, rd_val);
		check(rd_val, 8'h00, "word b reset");

		// Each row lands in command number code, so all eight slots are used
		foreach (rows[i]) begin
			logic [2:0] c;
			c = rows[i].code;
			wr(8'h11, {7'h00, rows[i].log_sel});
			wr(8'h30 + {4'h0, c, 1'b0}, {c, c, c[1:0]});
			wr(8'h31 + {4'h0, c, 1'b0}, {c[2:1], c, ~c});
			cmd_sel_i = c;
			repeat (2) @(posedge mclk_i);
			#1;
			check({1'b0, red_pct_o}, {1'b0, rows[i].pct}, "red pct");
			check({1'b0, green_pct_o}, {1'b0, rows[i].pct}, "green pct");
			check({1'b0, blue_pct_o}, {1'b0, rows[i].pct}, "blue pct");
			check({4'h0, exec_time_o}, {4'h0, c[1:0], c[2:1]}, "exec");
			check({5'h00, transition_time_o}, {5'h00, ~c}, "trans");
			rd(8'h30 + {4'h0, c, 1'b0}, rd_val);
			check(rd_val, {c, c, c[1:0]}, "word a");
			rd(8'h31 + {4'h0, c, 1'b0}, rd_val);
			check(rd_val, {c[2:1], c, ~c}, "word b");
		end

		// Reserved bits of pattern control and an unmapped address
		wr(8'h11, 8'hff);
		rd(8'h11, rd_val);
		check(rd_val, 8'h0f, "pattern ctrl");
		check({4'h0, pattern_ctrl_o}, 8'h0f, "pattern out");
		wr(8'h20, 8'h5a);
		rd(8'h20, rd_val);
		check(rd_val, 8'h00, "unmapped");
		// A write while the clock enable is low must be lost
		ce_i = 1'b0;
		wr(8'h2b, 8'h1f);
		ce_i = 1'b1;
		rd(8'h2b, rd_val);
		check(rd_val, 8'h00, "ce freeze");
		wr(8'h2b, 8'hff);
		rd(8'h2b, rd_val);
		check(rd_val, 8'h1f, "ctrl2 top bits");
		// Every filter mode code passes through untouched
		for (int m = 3; m >= 0; m--) begin
			wr(8'h2b, {4'h0, 2'(m), 2'b00});
			rd(8'h2b, rd_val);
			check(rd_val, {4'h0, 2'(m), 2'b00}, "mode rd");
			check({6'h00, filter_mode_o}, {6'h00, 2'(m)}, "mode out");
		end

		// Plain sampling, fastest follower
		audio_sample_i = 8'h80;
		wait_level(8'h80);
		check(led_level_o, 8'h80, "led fastest");
		wr(8'h2c, 8'h55);
		rd(8'h2c, rd_val);
		check(rd_val, 8'h80, "level read only");
		// Averaging holds the old level for the whole 64-sample window
		// Sample moves only after the mode write, so no plain tick can take it
		wr(8'h2b, 8'h10);
		audio_sample_i = 8'h40;
		repeat (400) @(posedge mclk_i);
		rd(8'h2c, rd_val);
		check(rd_val, 8'h80, "avg early");
		wait_level(8'h40);
		// Slow follower closes one eighth of the gap per update
		audio_sample_i = 8'hc0;
		wr(8'h2b, 8'h03);
		wait_level(8'hc0);
		check(led_level_o, 8'h50, "led slow");
		// Fast closes half the gap, medium a quarter
		wr(8'h2b, 8'h01);
		wait_led(8'h88, n_cyc);
		wr(8'h2b, 8'h02);
		wait_led(8'h96, n_cyc);
		// Next refresh comes exactly one plain divider period later
		wait_led(8'ha0, n_cyc);
		check(8'(n_cyc), 8'h14, "plain period");
		// Reset in mid-run clears registers and the follower
		@(posedge mclk_i) #1;
		reset_i = 1'b1;
		repeat (2) @(posedge mclk_i);
		#1;
		reset_i = 1'b0;
		check(led_level_o, 8'h00, "led re-reset");
		check({1'b0, red_pct_o}, 8'h00, "red re-reset");
		rd(8'h2b, rd_val);
		check(rd_val, 8'h00, "ctrl2 re-reset");
		rd(8'h3f, rd_val);
		check(rd_val, 8'h00, "word b re-reset");
		complete_run();
	end

endmodule
